// ---- afb_checker.sv ----
// afb_checker: assertions on the divider bank ports.
// assumes one clock; outputs trail a write by two edges.
`timescale 1ns/1ps
module afb_checker (
  input wire logic core_clk_in, reset_in, wr_en_in, rd_en_in, fb_den_zero_out,
  input wire logic [8:0] addr_in, input wire logic [7:0] wr_data_in, rd_data_out,
  input wire logic [15:0] fb_divide_value_out, input wire logic [31:0] fb_divide_denominator_out);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  sequence wr_rd; wr_en_in && addr_in - 9'h109 < 7 ##1 rd_en_in && $stable(addr_in); endsequence
  property lands(a, v); wr_en_in && addr_in == a |-> ##2 v == $past(wr_data_in, 2); endproperty
  rd_idle_a: assert property (!$past(rd_en_in) |-> rd_data_out == 8'h00)
    else $error("stray read data");
  rd_back_a: assert property (wr_rd |=> rd_data_out == $past(wr_data_in, 2))
    else $error("bad read back");
  div_lo_a: assert property (lands(9'h10A, fb_divide_value_out[7:0]))
    else $error("byte five lost");
  div_hi_a: assert property (lands(9'h10B, fb_divide_value_out[15:8]))
    else $error("byte six lost");
  den_lo_a: assert property (lands(9'h10C, fb_divide_denominator_out[7:0]))
    else $error("low byte lost");
  den_b2_a: assert property (lands(9'h10D, fb_divide_denominator_out[15:8]))
    else $error("byte two lost");
  den_reset_a: assert property ($fell(reset_in) |-> fb_divide_denominator_out == 32'h1)
    else $error("bad reset value");
  den_zero_a: assert property (!fb_divide_denominator_out |-> ##[0:1] fb_den_zero_out)
    else $error("zero not flagged");
endmodule : afb_checker
bind afb_feedback_divider_regs afb_checker i_chk (.*);

// ---- afb_feedback_divider_regs.sv ----
// afb_feedback_divider_regs: feedback divider byte registers of the analog pll.
// assumes a plain register port on core_clk_in; read data valid the cycle after read strobe.
// Operation
// - hold divide value bits 31:24 in a byte, reset zero.
// - divide value bits 39:32 at offset 0x10A, reset zero.
// - next divide value byte at offset 0x10B, reset zero.
// - 32-bit denominator from four bytes, lowest byte at 0x10C.
// - lowest denominator byte resets to one.
// - denominator is an unsigned integer for the fractional ratio.
// - denominator bits 15:8 at offset 0x10D.
`timescale 1ns/1ps
module afb_feedback_divider_regs (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic reset_in,
  // register port
  input wire logic [8:0] addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  output logic [7:0] rd_data_out,
  // settings towards the pll datapath
  output logic [15:0] fb_divide_value_out,
  output logic [31:0] fb_divide_denominator_out,
  output logic fb_den_zero_out
);
  // storage, one entry per byte; the last entry is a hole that always reads zero
  logic [7:0] byte_q [afb_pkg::NUM_REGS];
  logic [afb_pkg::NUM_REGS-1:0] hit;
  logic [afb_pkg::NUM_REGS-1:0] wr_sel;
  logic [8:0] idx;
  logic in_bank;
  logic [7:0] next_rd_data;
  logic [7:0] status_byte;
  logic [31:0] den_w;
  logic [15:0] div_w;
  logic den_is_zero;
  logic den_is_one;

  // named views of the stored bytes
  logic [7:0] fb_div_byte4;
  logic [7:0] fb_div_byte5;
  logic [7:0] fb_div_byte6;
  logic [7:0] fb_denominator_byte1;
  logic [7:0] fb_denominator_byte2;
  logic [7:0] fb_denominator_byte3;
  logic [7:0] fb_denominator_byte4;

  // below the base the subtraction wraps, so the range test guards the index
  assign in_bank = (addr_in >= afb_pkg::BANK_BASE);
  assign idx = addr_in - afb_pkg::BANK_BASE;

  // entry 0..2 divide bytes 4..6, entry 3..6 denominator bytes 1..4
  genvar g;
  generate
    for (g = 0; g < afb_pkg::NUM_REGS - 1; g++) begin : g_byte
      localparam logic [7:0] RV = (g == 3) ? afb_pkg::FB_DENOMINATOR_BYTE1_RST :
        (g > 3) ? afb_pkg::FB_DENOMINATOR_BYTE_RST : afb_pkg::FB_DIV_BYTE_RST;
      assign hit[g] = in_bank && (idx == 9'(g));
      assign wr_sel[g] = wr_en_in && hit[g];
      afb_reg_byte #(.RESET_VALUE(RV)) u_byte (
        .core_clk_in(core_clk_in),
        .reset_in(reset_in),
        .wr_en_in(wr_sel[g]),
        .wr_data_in(wr_data_in),
        .value_out(byte_q[g])
      );
    end
  endgenerate

  // the hole never decodes, so a write there is dropped
  assign hit[afb_pkg::NUM_REGS-1] = 1'b0;
  assign wr_sel[afb_pkg::NUM_REGS-1] = 1'b0;
  assign byte_q[afb_pkg::NUM_REGS-1] = afb_pkg::READ_ZERO;

  assign fb_div_byte4 = byte_q[0];
  assign fb_div_byte5 = byte_q[1];
  assign fb_div_byte6 = byte_q[2];
  assign fb_denominator_byte1 = byte_q[3];
  assign fb_denominator_byte2 = byte_q[4];
  assign fb_denominator_byte3 = byte_q[5];
  assign fb_denominator_byte4 = byte_q[6];

  // wide values for the datapath; denominator low byte first in the map
  assign div_w = {fb_div_byte6, fb_div_byte5};
  assign den_w = {fb_denominator_byte4, fb_denominator_byte3,
                  fb_denominator_byte2, fb_denominator_byte1};
  assign den_is_zero = (den_w == 32'h0000_0000);
  assign den_is_one = (den_w == 32'h0000_0001);

  // status is observation only: hardware never rewrites the denominator
  always_comb begin
    status_byte = afb_pkg::READ_ZERO;
    status_byte[afb_pkg::STAT_DEN_ZERO_BIT] = den_is_zero;
    status_byte[afb_pkg::STAT_DEN_ONE_BIT] = den_is_one;
  end

  // read select; unmapped offsets read zero
  always_comb begin
    next_rd_data = afb_pkg::READ_ZERO;
    unique case (addr_in)
      afb_pkg::FB_DIV_BYTE4_OFF: begin
        next_rd_data = fb_div_byte4;
      end
      afb_pkg::FB_DIV_BYTE5_OFF: begin
        next_rd_data = fb_div_byte5;
      end
      afb_pkg::FB_DIV_BYTE6_OFF: begin
        next_rd_data = fb_div_byte6;
      end
      afb_pkg::FB_DENOMINATOR_BYTE1_OFF: begin
        next_rd_data = fb_denominator_byte1;
      end
      afb_pkg::FB_DENOMINATOR_BYTE2_OFF: begin
        next_rd_data = fb_denominator_byte2;
      end
      afb_pkg::FB_DENOMINATOR_BYTE3_OFF: begin
        next_rd_data = fb_denominator_byte3;
      end
      afb_pkg::FB_DENOMINATOR_BYTE4_OFF: begin
        next_rd_data = fb_denominator_byte4;
      end
      afb_pkg::FB_STATUS_OFF: begin
        next_rd_data = status_byte;
      end
      default: begin
        next_rd_data = afb_pkg::READ_ZERO;
      end
    endcase
  end

  // zero outside the answer cycle, so a late sample cannot pass for data
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rd_data_out <= afb_pkg::READ_ZERO;
    end else if (rd_en_in) begin
      rd_data_out <= next_rd_data;
    end else begin
      rd_data_out <= afb_pkg::READ_ZERO;
    end
  end

  // divide value copy towards the datapath
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      fb_divide_value_out <= {2{afb_pkg::FB_DIV_BYTE_RST}};
    end else begin
      fb_divide_value_out <= div_w;
    end
  end

  // denominator copy; a zero is passed through, correcting it would hide a software fault
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      fb_divide_denominator_out <= {{3{afb_pkg::FB_DENOMINATOR_BYTE_RST}},
                                    afb_pkg::FB_DENOMINATOR_BYTE1_RST};
    end else begin
      fb_divide_denominator_out <= den_w;
    end
  end

  // zero flag, in step with the denominator copy
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      fb_den_zero_out <= 1'b0;
    end else begin
      fb_den_zero_out <= den_is_zero;
    end
  end
endmodule : afb_feedback_divider_regs

// ---- afb_feedback_divider_regs_test.sv ----
// afb_feedback_divider_regs_test: register bank test over the plain port.
// assumes read data in the cycle after the read strobe.
`timescale 1ns/1ps
module afb_feedback_divider_regs_test;
  logic core_clk_in = 1'b0, reset_in, wr_en_in, rd_en_in, fb_den_zero_out;
  logic [8:0] addr_in;
  logic [7:0] wr_data_in, rd_data_out;
  logic [15:0] fb_divide_value_out;
  logic [31:0] fb_divide_denominator_out;
  int fails = 0, samples_checked = 0;
  afb_feedback_divider_regs i_dut (.*);
  initial forever #5 core_clk_in = ~core_clk_in;
  task automatic chk(input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) fails++;
    if (seen !== exp) $display("Error %0t got %h want %h", $time, seen, exp);
  endtask : chk
  task automatic op(input logic w, r, input logic [8:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    {wr_en_in, rd_en_in, addr_in, wr_data_in} <= {w, r, a, d};
  endtask : op
  task automatic rdc(input logic [8:0] a, input logic [7:0] e);
    op('0, '1, a, '0);
    op('0, '0, a, '0);
    #1 chk(rd_data_out, e);
  endtask : rdc
  task automatic close_out;
    if (fails == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  initial begin
    {reset_in, wr_en_in, rd_en_in, addr_in, wr_data_in} = {3'b100, 17'h0_0000};
    repeat (5) @(posedge core_clk_in);
    reset_in <= 1'b0;
    for (logic [8:0] a = 9'h109; a < 9'h110; a++) begin
      rdc(a, 8'(a == 9'h10C));
      op('1, '0, a, a[7:0] ^ 8'h5A);
      rdc(a, a[7:0] ^ 8'h5A);
    end
    chk(fb_divide_value_out, 16'h5150);
    chk(fb_divide_denominator_out, 32'h5554_5756);
    rdc(9'h100, 8'h00);
    for (logic [8:0] a = 9'h10C; a < 9'h110; a++) op('1, '0, a, '0);
    repeat (3) op('0, '0, '0, '0);
    #1 chk(fb_den_zero_out, 1'b1);
    rdc(afb_pkg::FB_STATUS_OFF, 8'h01);
    op('1, '0, 9'h10C, 8'h01);
    rdc(afb_pkg::FB_STATUS_OFF, 8'h02);
    repeat (2) op('0, '0, '0, '0);
    #1 chk(fb_den_zero_out, 1'b0);
    chk(fb_divide_denominator_out, 32'h0000_0001);
    close_out();
  end
endmodule : afb_feedback_divider_regs_test

// ---- afb_pkg.sv ----
// afb_pkg: register map, field layouts and reset values of the feedback divider bank.
// assumes byte-wide registers reached over a plain address/strobe port.
package afb_pkg;
  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;
  localparam int NUM_REGS = 8;
  // register offsets
  localparam logic [8:0] FB_DIV_BYTE4_OFF = 9'h109;
  localparam logic [8:0] FB_DIV_BYTE5_OFF = 9'h10A;
  localparam logic [8:0] FB_DIV_BYTE6_OFF = 9'h10B;
  localparam logic [8:0] FB_DENOMINATOR_BYTE1_OFF = 9'h10C;
  localparam logic [8:0] FB_DENOMINATOR_BYTE2_OFF = 9'h10D;
  localparam logic [8:0] FB_DENOMINATOR_BYTE3_OFF = 9'h10E;
  localparam logic [8:0] FB_DENOMINATOR_BYTE4_OFF = 9'h10F;
  localparam logic [8:0] FB_STATUS_OFF = 9'h1F0;
  // base of the bank, entry index is address minus base
  localparam logic [8:0] BANK_BASE = 9'h109;
  // field positions inside the wide divide value
  localparam int DIV_BYTE4_LSB = 24;
  localparam int DIV_BYTE5_LSB = 32;
  localparam int DIV_BYTE6_LSB = 40;
  localparam int DIV_W = 48;
  localparam int DEN_W = 32;
  // reset values
  localparam logic [7:0] FB_DIV_BYTE_RST = 8'h00;
  localparam logic [7:0] FB_DENOMINATOR_BYTE1_RST = 8'h01;
  localparam logic [7:0] FB_DENOMINATOR_BYTE_RST = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  // status bits
  localparam int STAT_DEN_ZERO_BIT = 0;
  localparam int STAT_DEN_ONE_BIT = 1;
endpackage : afb_pkg

// ---- afb_reg_byte.sv ----
// afb_reg_byte: one 8-bit read/write storage byte with its own reset value.
// assumes a single clock domain and a one-cycle write strobe.
`timescale 1ns/1ps
module afb_reg_byte #(
  parameter logic [7:0] RESET_VALUE = 8'h00
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic reset_in,
  // write side
  input wire logic wr_en_in,
  input wire logic [7:0] wr_data_in,
  // stored value
  output logic [7:0] value_out
);
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      value_out <= RESET_VALUE;
    end else if (wr_en_in) begin
      value_out <= wr_data_in;
    end
  end
endmodule : afb_reg_byte
